// File: src/plk_pkg.sv
`default_nettype none
package plk_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int GRANT_CYC = 1;
  localparam int CONCAT_WAIT_NS = 100;
  localparam int CONCAT_WAIT_CYC = (CONCAT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PREFIX_EXT_NS = 400;
  localparam int PREFIX_EXT_CYC = (PREFIX_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Control line codes, device side
  localparam logic [1:0] DEV_IDLE = 2'h0;
  localparam logic [1:0] DEV_STATUS = 2'h1;
  localparam logic [1:0] DEV_RECEIVE = 2'h2;
  localparam logic [1:0] DEV_TRANSMIT = 2'h3;
  // Control line codes, link side
  localparam logic [1:0] LNK_IDLE = 2'h0;
  localparam logic [1:0] LNK_HOLD = 2'h1;
  localparam logic [1:0] LNK_TRANSMIT = 2'h2;
  // Status word layout
  localparam int ST_ARB_GAP = 0;
  localparam int ST_SUB_GAP = 1;
  localparam int ST_BUS_RESET = 2;
  localparam int ST_TIMEOUT = 3;
  localparam int ST_ADDR_LSB = 4;
  localparam int ST_DATA_LSB = 8;
  localparam int SHORT_CYC = 2;
  localparam int FULL_CYC = 8;
  // Receive lead-in and speed codes
  localparam logic [3:0] RX_LEAD = 4'hF;
  localparam logic [3:0] SPD_100 = 4'h0;
  localparam logic [3:0] SPD_200 = 4'h4;
  // Request types and stream lengths
  localparam logic [2:0] RQ_IMM = 3'h0;
  localparam logic [2:0] RQ_ISO = 3'h1;
  localparam logic [2:0] RQ_PRI = 3'h2;
  localparam logic [2:0] RQ_FAIR = 3'h3;
  localparam logic [2:0] RQ_RD = 3'h4;
  localparam logic [2:0] RQ_WR = 3'h5;
  localparam logic [4:0] LEN_BUS = 5'h07;
  localparam logic [4:0] LEN_RD = 5'h09;
  localparam logic [4:0] LEN_WR = 5'h11;
  // Bus register map
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam int CTRL_ROOT_BIT = 0;
  localparam int CTRL_SEND_BIT = 1;
  localparam int CTRL_ADDR_LSB = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
endpackage
`default_nettype wire

// File: src/plk_link_request_line_rx.sv
`timescale 1ns/1ps
`default_nettype none
module plk_req_rx
  import plk_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Synchronised request line
  input wire logic req_line_in,
  // Decoded request
  output logic req_valid,
  output logic [2:0] req_type,
  output logic [3:0] req_addr,
  output logic [7:0] req_data
);
  typedef struct packed {
    logic active;
    logic [4:0] cnt;
    logic [16:0] sr;
    logic valid;
    logic [2:0] rtype;
    logic [3:0] addr;
    logic [7:0] data;
  } plk_req_t;

  plk_req_t q, n;

  function automatic logic [4:0] stream_len(input logic [2:0] t);
    stream_len = (t == RQ_RD) ? LEN_RD : (t == RQ_WR) ? LEN_WR : LEN_BUS;
  endfunction

  always_comb begin
    logic [2:0] t;
    t = '0;
    n = q;
    n.valid = 1'b0;
    if (!q.active) begin
      // Start bit opens a stream
      if (req_line_in) begin
        n.active = 1'b1;
        n.sr = 17'h00001;
        n.cnt = 5'h01;
      end
    end else begin
      n.sr[q.cnt] = req_line_in;
      n.cnt = q.cnt + 5'h01;
      t = {n.sr[1], n.sr[2], n.sr[3]};
      // Stop bit position reached; type is known by then
      if (q.cnt >= 5'h04 && q.cnt == stream_len(t) - 5'h01) begin
        n.active = 1'b0;
        n.valid = 1'b1;
        n.rtype = t;
        n.addr = {n.sr[4], n.sr[5], n.sr[6], n.sr[7]};
        n.data = {n.sr[8], n.sr[9], n.sr[10], n.sr[11],
                  n.sr[12], n.sr[13], n.sr[14], n.sr[15]};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign req_valid = q.valid;
  assign req_type = q.rtype;
  assign req_addr = q.addr;
  assign req_data = q.data;
endmodule // plk_req_rx
`default_nettype wire

// File: src/plk_phy_link.sv
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Function
// [RULE_01] Status goes out as sixteen ordered bits
// [RULE_02] Bit 0 flags arbitration reset gap
// [RULE_03] Bit 1 flags subaction gap
// [RULE_04] Bit 2 flags bus reset entered
// [RULE_05] Bit 3 flags state timeout or power low
// [RULE_06] Full status carries register address and data
// [RULE_07] Link bus request starts arbitration
// [RULE_08] Grant is transmit then one idle cycle
// [RULE_09] Link hold keeps bus via data prefix
// [RULE_10] Link sends packet under transmit code
// [RULE_11] Link ends packet with one idle cycle
// [RULE_12] Hold after packet: wait, then grant again
// [RULE_13] After link idle device drives idle
// [RULE_14] Concatenated packets keep one speed
// [RULE_15] Root isochronous send stretches data prefix
// [RULE_16] Receive opens with all data lines high
// [RULE_17] Speed code marks start, then packet data
// [RULE_18] Idle ends the receive operation
// [RULE_19] Speed codes 0000 and 0100
// [RULE_20] Speed code stays out of the CRC
// [RULE_21] Status starts only from idle, code 01
// [RULE_22] Receive code is 10
// [RULE_23] Short status normally, full on request
// [RULE_24] Published control codes on both sides
module plk_phy_link
  import plk_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Link pins
  input wire logic link_request_line,
  input wire logic [1:0] interface_control_lines_in,
  output logic [1:0] interface_control_lines_out,
  output logic interface_control_lines_oe_n,
  input wire logic [3:0] link_data_in,
  output logic [3:0] link_data_out,
  output logic link_data_oe_n,
  // Serial bus core events
  input wire logic ev_arb_reset_gap,
  input wire logic ev_subaction_gap,
  input wire logic ev_bus_reset,
  input wire logic ev_state_timeout,
  input wire logic cable_power_low_flag,
  // Arbitration and transmit path
  output logic arb_req,
  output logic arb_iso,
  input wire logic arb_won,
  output logic bus_prefix,
  output logic bus_tx_valid,
  output logic [3:0] bus_tx_data,
  // Receive path
  input wire logic rx_start,
  input wire logic rx_speed_200,
  input wire logic rx_valid,
  input wire logic [3:0] rx_data,
  input wire logic rx_end
);
  typedef enum logic [3:0] {
    S_IDLE, S_STATUS, S_ARB, S_PREFIX_EXT, S_GRANT, S_GRANT_IDLE, S_LINK,
    S_CONCAT, S_RX_ONES, S_RX_SPEED, S_RX_DATA, S_END_IDLE
  } plk_state_t;

  typedef struct packed {
    plk_state_t st;
    logic [7:0] cnt;
    logic [1:0] req_s;
    logic [1:0] icl_s1;
    logic [1:0] icl_s2;
    logic [3:0] d_s1;
    logic [3:0] d_s2;
    logic [3:0] pend;
    logic [3:0] sent;
    logic full_pend;
    logic [3:0] full_addr;
    logic full;
    logic [15:0] sr;
    logic req_pend;
    logic req_iso;
    logic seen_tx;
    logic spd;
    logic root;
    logic [3:0] ctrl_addr;
    logic [15:0][7:0] regs;
    logic ahb_wr;
    logic [11:0] ahb_addr;
    logic [31:0] rdata;
    logic [1:0] icl;
    logic oe_n;
    logic [3:0] dout;
    logic prefix;
    logic txv;
    logic [3:0] txd;
    logic arbr;
  } plk_core_t;

  plk_core_t q, n;
  logic rq_valid;
  logic [2:0] rq_type;
  logic [3:0] rq_addr;
  logic [7:0] rq_data;
  logic [3:0] ev;

  plk_req_rx u_req (
    .hclk(hclk),
    .hresetn(hresetn),
    .req_line_in(q.req_s[1]),
    .req_valid(rq_valid),
    .req_type(rq_type),
    .req_addr(rq_addr),
    .req_data(rq_data)
  );

  // Bit order on the wire: bit 0 first, field MSB first
  function automatic logic [15:0] status_word(input logic [3:0] flags,
                                              input logic [3:0] addr,
                                              input logic [7:0] data);
    logic [15:0] w;
    w = '0;
    w[ST_TIMEOUT:ST_ARB_GAP] = flags; // RULE_01
    for (int i = 0; i < 4; i++) begin
      w[ST_ADDR_LSB + i] = addr[3 - i]; // RULE_06
    end
    for (int i = 0; i < 8; i++) begin
      w[ST_DATA_LSB + i] = data[7 - i]; // RULE_06
    end
    status_word = w;
  endfunction

  function automatic logic [31:0] reg_read(input logic [11:0] a, input plk_core_t s);
    logic [31:0] v;
    v = '0;
    if (a == REG_CTRL) begin
      v[CTRL_ROOT_BIT] = s.root;
      v[CTRL_ADDR_LSB +: 4] = s.ctrl_addr;
    end else if (a == REG_STAT) begin
      v[3:0] = s.st;
      v[7:4] = s.pend;
      v[8] = s.full_pend;
      v[9] = s.req_pend;
      v[10] = s.req_iso;
    end
    reg_read = v;
  endfunction

  // Events from the serial core
  assign ev[ST_ARB_GAP] = ev_arb_reset_gap; // RULE_02
  assign ev[ST_SUB_GAP] = ev_subaction_gap; // RULE_03
  assign ev[ST_BUS_RESET] = ev_bus_reset; // RULE_04
  assign ev[ST_TIMEOUT] = ev_state_timeout | cable_power_low_flag; // RULE_05

  always_comb begin
    n = q;
    n.req_s = {q.req_s[0], link_request_line};
    n.icl_s1 = interface_control_lines_in;
    n.icl_s2 = q.icl_s1;
    n.d_s1 = link_data_in;
    n.d_s2 = q.d_s1;
    n.prefix = 1'b0;
    n.txv = 1'b0;
    n.arbr = 1'b0;
    unique case (q.st)
      S_IDLE: begin
        if (rx_start) begin
          n.st = S_RX_ONES;
          n.spd = rx_speed_200;
        end else if (q.req_pend) begin
          n.st = S_ARB; // RULE_07
          n.req_pend = 1'b0;
        end else if (q.icl_s2 == LNK_IDLE && (q.pend != 4'h0 || q.full_pend)) begin
          n.st = S_STATUS; // RULE_21
          n.full = q.full_pend;
          n.sent = q.pend;
          n.sr = status_word(q.pend, q.full_addr, q.regs[q.full_addr]);
          n.cnt = q.full_pend ? 8'(FULL_CYC - 1) : 8'(SHORT_CYC - 1); // RULE_23
        end
      end
      S_STATUS: begin
        // Preempted transfers stay pending and retry from idle
        if (rx_start) begin
          n.st = S_RX_ONES;
          n.spd = rx_speed_200;
        end else if (q.cnt == 8'h00) begin
          n.st = S_END_IDLE;
          n.pend = q.pend & ~q.sent;
          n.full_pend = q.full_pend & ~q.full;
        end else begin
          n.sr = q.sr >> 2;
          n.cnt = q.cnt - 8'h01;
        end
      end
      S_ARB: begin
        n.arbr = 1'b1; // RULE_07
        // A lost request is dropped; the link reissues after idle
        if (rx_start) begin
          n.st = S_RX_ONES;
          n.spd = rx_speed_200;
        end else if (arb_won) begin
          if (q.root && q.req_iso) begin
            n.st = S_PREFIX_EXT; // RULE_15
            n.cnt = 8'(PREFIX_EXT_CYC - 1);
          end else begin
            n.st = S_GRANT;
            n.cnt = 8'(GRANT_CYC - 1);
          end
        end
      end
      S_PREFIX_EXT: begin
        n.prefix = 1'b1; // RULE_15
        if (q.cnt == 8'h00) begin
          n.st = S_GRANT;
          n.cnt = 8'(GRANT_CYC - 1);
        end else begin
          n.cnt = q.cnt - 8'h01;
        end
      end
      S_GRANT: begin
        n.seen_tx = 1'b0;
        if (q.cnt == 8'h00) begin
          n.st = S_GRANT_IDLE; // RULE_08
        end else begin
          n.cnt = q.cnt - 8'h01;
        end
      end
      S_GRANT_IDLE: begin
        n.st = S_LINK;
      end
      S_LINK: begin
        // Our own grant codes echo through the synchroniser; 11 is ignored
        if (q.icl_s2 == LNK_HOLD) begin
          if (q.seen_tx) begin
            n.st = S_CONCAT; // RULE_12
            n.cnt = 8'(CONCAT_WAIT_CYC - 1);
          end else begin
            n.prefix = 1'b1; // RULE_09
          end
        end else if (q.icl_s2 == LNK_TRANSMIT) begin
          n.txv = 1'b1;
          n.txd = q.d_s2;
          n.seen_tx = 1'b1;
        end else if (q.icl_s2 == LNK_IDLE && q.seen_tx) begin
          n.st = S_END_IDLE; // RULE_13
        end
      end
      S_CONCAT: begin
        n.prefix = 1'b1;
        if (q.cnt == 8'h00) begin
          n.st = S_GRANT; // RULE_12
          n.cnt = 8'(GRANT_CYC - 1);
        end else begin
          n.cnt = q.cnt - 8'h01;
        end
      end
      S_RX_ONES: begin
        n.st = S_RX_SPEED; // RULE_17
      end
      S_RX_SPEED: begin
        n.st = S_RX_DATA;
      end
      S_RX_DATA: begin
        if (rx_end) begin
          n.st = S_END_IDLE; // RULE_18
        end
      end
      S_END_IDLE: begin
        n.st = S_IDLE;
      end
    endcase

    // Sets after clears, so an event in the clearing cycle survives
    n.pend = n.pend | ev;
    if (rq_valid) begin
      if (rq_type == RQ_RD) begin
        n.full_pend = 1'b1; // RULE_23
        n.full_addr = rq_addr;
      end else if (rq_type == RQ_WR) begin
        n.regs[rq_addr] = rq_data;
      end else if (rq_type <= RQ_FAIR) begin
        n.req_pend = 1'b1;
        n.req_iso = (rq_type == RQ_ISO);
      end
    end

    // Zero-wait AHB slave; unmapped reads return zero
    n.ahb_wr = hsel && hready && htrans[1] && hwrite;
    n.ahb_addr = haddr[11:0];
    if (hsel && hready && htrans[1] && !hwrite) begin
      n.rdata = reg_read(haddr[11:0], q);
    end
    if (q.ahb_wr && q.ahb_addr == REG_CTRL) begin
      n.root = hwdata[CTRL_ROOT_BIT];
      n.ctrl_addr = hwdata[CTRL_ADDR_LSB +: 4];
      if (hwdata[CTRL_SEND_BIT]) begin
        n.full_pend = 1'b1;
        n.full_addr = hwdata[CTRL_ADDR_LSB +: 4];
      end
    end

    // Pin drive follows the next state
    n.oe_n = (n.st == S_LINK);
    unique case (n.st)
      S_STATUS: n.icl = DEV_STATUS; // RULE_24
      S_GRANT: n.icl = DEV_TRANSMIT; // RULE_08
      S_RX_ONES, S_RX_SPEED, S_RX_DATA: n.icl = DEV_RECEIVE; // RULE_22
      default: n.icl = DEV_IDLE;
    endcase
    unique case (n.st)
      S_STATUS: n.dout = {2'h0, n.sr[1:0]}; // RULE_21
      S_RX_ONES: n.dout = RX_LEAD; // RULE_16
      S_RX_SPEED: n.dout = n.spd ? SPD_200 : SPD_100; // RULE_19
      S_RX_DATA: n.dout = rx_valid ? rx_data : q.dout;
      default: n.dout = 4'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign hrdata = q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign interface_control_lines_out = q.icl;
  assign interface_control_lines_oe_n = q.oe_n;
  assign link_data_out = q.dout;
  assign link_data_oe_n = q.oe_n;
  assign arb_req = q.arbr;
  assign arb_iso = q.req_iso;
  assign bus_prefix = q.prefix;
  assign bus_tx_valid = q.txv;
  assign bus_tx_data = q.txd;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence rx_lead_s;
    q.st == S_RX_ONES && link_data_out == RX_LEAD && q.icl == DEV_RECEIVE;
  endsequence
  sequence rx_speed_s;
    q.st == S_RX_SPEED && q.icl == DEV_RECEIVE &&
      link_data_out == (q.spd ? SPD_200 : SPD_100);
  endsequence

  a_grant_idle_follow: assert property ( // RULE_08
    q.st == S_GRANT && q.cnt == 8'h00 |=> q.st == S_GRANT_IDLE && q.icl == DEV_IDLE
      && !q.oe_n ##1 q.oe_n)
    else $error("grant not followed by one idle cycle");
  a_status_from_idle: assert property ( // RULE_21
    $rose(q.st == S_STATUS) |-> $past(q.icl) == DEV_IDLE && q.icl == DEV_STATUS)
    else $error("status transfer did not start from idle");
  a_status_length: assert property ( // RULE_23
    $rose(q.st == S_STATUS) |-> q.cnt == (q.full ? 8'h07 : 8'h01))
    else $error("status transfer length wrong");
  a_rx_sequence: assert property ( // RULE_16
    $rose(q.st == S_RX_ONES) |-> rx_lead_s ##1 rx_speed_s)
    else $error("receive lead-in or speed code wrong");
  a_rx_end_idle: assert property ( // RULE_18
    q.st == S_RX_DATA && rx_end |=> q.icl == DEV_IDLE && !q.oe_n)
    else $error("receive not ended by idle");
  a_reset_flag: assert property ( // RULE_04
    ev_bus_reset |=> q.pend[ST_BUS_RESET])
    else $error("bus reset flag not set");
  a_timeout_flag: assert property ( // RULE_05
    ev_state_timeout || cable_power_low_flag |=> q.pend[ST_TIMEOUT])
    else $error("timeout flag not set");
  a_arb_request: assert property ( // RULE_07
    q.st == S_IDLE && q.req_pend && !rx_start |=> ##1 arb_req)
    else $error("no arbitration after bus request");
  a_hold_prefix: assert property ( // RULE_09
    q.st == S_LINK && q.icl_s2 == LNK_HOLD && !q.seen_tx |=> bus_prefix)
    else $error("hold did not keep data prefix");
  a_concat_wait: assert property ( // RULE_12
    $rose(q.st == S_CONCAT) |-> q.cnt == 8'(CONCAT_WAIT_CYC - 1) && bus_prefix == 1'b0
      ##1 bus_prefix)
    else $error("concatenation wait wrong");
  a_link_idle_end: assert property ( // RULE_13
    q.st == S_LINK && q.seen_tx && q.icl_s2 == LNK_IDLE |=> !q.oe_n
      && q.icl == DEV_IDLE ##1 q.st == S_IDLE)
    else $error("device did not drive idle after link");
  a_root_prefix: assert property ( // RULE_15
    q.st == S_ARB && arb_won && q.root && q.req_iso && !rx_start |=> q.st == S_PREFIX_EXT
      ##1 bus_prefix)
    else $error("root isochronous prefix not stretched");
endmodule // plk_phy_link
`default_nettype wire

// File: test/plk_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module plk_link_model
  import plk_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Device drive
  input wire logic [1:0] icl_out,
  input wire logic icl_oe_n,
  input wire logic [3:0] dat_out,
  input wire logic dat_oe_n,
  // Resolved pins
  output logic req_line,
  output logic [1:0] icl_in,
  output logic [3:0] dat_in
);
  logic [1:0] icl_q;
  logic [3:0] dat_q;
  logic own_q;
  // Released lines show the inverse of the last value, never a kind guess
  assign icl_in = !icl_oe_n ? icl_out : (own_q ? icl_q : ~icl_q);
  assign dat_in = !dat_oe_n ? dat_out : (own_q ? dat_q : ~dat_q);
  initial begin
    req_line = 1'b0;
  end
  // Idle stands one cycle, then the link lets go of the lines
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      own_q <= 1'b0;
      icl_q <= LNK_IDLE;
      dat_q <= 4'h0;
    end else if (own_q && icl_q == LNK_IDLE) begin
      own_q <= 1'b0;
    end
  end
  task automatic drive(input logic [1:0] c, input logic [3:0] d);
    @(posedge hclk);
    icl_q <= c;
    dat_q <= d;
    own_q <= 1'b1;
  endtask
  // Request stream, first bit first
  task automatic send_req(input logic [16:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge hclk);
      req_line <= bits[i];
    end
  endtask
  // One packet at one rate, four bits a cycle, then idle or hold
  task automatic packet(input logic [15:0] p, input logic [1:0] after);
    for (int i = 3; i >= 0; i--) drive(LNK_TRANSMIT, p[4*i +: 4]);
    drive(after, 4'h0);
  endtask
endmodule // plk_link_model
`default_nettype wire

// File: test/test_phy_link_status_tx_rx.sv
`timescale 1ns/1ps
`default_nettype none
module test_phy_link_status_tx_rx
  import plk_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, lrl, icl_oe_n, dat_oe_n;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, icl_in, icl_out;
  logic [3:0] dat_in, dat_out, rx_data, tx_data;
  logic [4:0] ev;
  logic arb_req, arb_iso, arb_won, prefix, tx_valid, rx_start, rx_spd, rx_valid, rx_end;
  logic [15:0] st;
  logic [3:0] txq[$];
  int mismatches, tests_run, pfx_cnt, w;

  plk_phy_link DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_request_line(lrl),
    .interface_control_lines_in(icl_in), .interface_control_lines_out(icl_out),
    .interface_control_lines_oe_n(icl_oe_n), .link_data_in(dat_in),
    .link_data_out(dat_out), .link_data_oe_n(dat_oe_n), .ev_arb_reset_gap(ev[0]),
    .ev_subaction_gap(ev[1]), .ev_bus_reset(ev[2]), .ev_state_timeout(ev[3]),
    .cable_power_low_flag(ev[4]), .arb_req(arb_req), .arb_iso(arb_iso), .arb_won(arb_won),
    .bus_prefix(prefix), .bus_tx_valid(tx_valid), .bus_tx_data(tx_data),
    .rx_start(rx_start), .rx_speed_200(rx_spd), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_end(rx_end)
  );
  plk_link_model lnk (
    .hclk(hclk), .hresetn(hresetn), .icl_out(icl_out), .icl_oe_n(icl_oe_n),
    .dat_out(dat_out), .dat_oe_n(dat_oe_n), .req_line(lrl), .icl_in(icl_in), .dat_in(dat_in)
  );

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Bus-side nibbles and prefix cycles, sampled mid-cycle
  always @(negedge hclk) begin
    if (tx_valid === 1'b1) txq.push_back(tx_data);
    if (prefix === 1'b1) pfx_cnt++;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // Bounded wait; a hang shows as one failed check, not a stuck run
  task wait_icl(input logic [1:0] c, input logic oe, output int n);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (!(icl_out === c && icl_oe_n === oe) && n < 300);
    if (n >= 300) chk(32'h0, 32'h1);
  endtask
  task pulse(input logic [4:0] v);
    @(posedge hclk);
    ev <= v;
    @(posedge hclk);
    ev <= 5'h00;
  endtask
  task get_status(input int n, output logic [15:0] s);
    int k;
    s = 16'h0000;
    wait_icl(DEV_STATUS, 1'b0, w);
    for (k = 0; k < n; k++) begin
      chk(icl_out, 2'h1);
      s[2*k] = dat_out[0];
      s[2*k+1] = dat_out[1];
      @(negedge hclk);
    end
    chk(icl_out, 2'h0);
  endtask
  function automatic logic [11:0] exp_full(input logic [3:0] a, input logic [7:0] d);
    logic [11:0] r;
    for (int i = 0; i < 4; i++) r[i] = a[3-i];
    for (int i = 0; i < 8; i++) r[4+i] = d[7-i];
    return r;
  endfunction
  task grant(output int n);
    wait_icl(DEV_TRANSMIT, 1'b0, n);
    @(negedge hclk);
    chk({dat_oe_n, icl_oe_n, icl_out}, 4'h0);
  endtask

  task t_flags;
    pulse(5'h05);
    get_status(2, st);
    chk(st[3:0], 4'h5);
    pulse(5'h0A);
    get_status(2, st);
    chk(st[3:0], 4'hA);
    pulse(5'h10);
    get_status(2, st);
    chk(st[3:0], 4'h8);
  endtask
  task t_full;
    lnk.send_req({1'b1, RQ_WR, 4'h5, 8'hA5, 1'b0}, 17);
    repeat (4) @(posedge hclk);
    lnk.send_req({8'h00, 1'b1, RQ_RD, 4'h5, 1'b0}, 9);
    get_status(8, st);
    chk(st[15:4], exp_full(4'h5, 8'hA5));
    ahb(1'b1, {20'h00000, REG_CTRL}, 32'h0000_0052, rd);
    get_status(8, st);
    chk(st[15:4], exp_full(4'h5, 8'hA5));
    ahb(1'b0, {20'h00000, REG_CTRL}, 32'h0000_0000, rd);
    chk(rd & 32'h0000_00F1, 32'h0000_0050);
    ahb(1'b0, 32'h0000_0010, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
  endtask
  task t_rx(input logic spd);
    @(posedge hclk);
    rx_start <= 1'b1;
    rx_spd <= spd;
    ev <= spd ? 5'h04 : 5'h00;
    @(posedge hclk);
    rx_start <= 1'b0;
    ev <= 5'h00;
    wait_icl(DEV_RECEIVE, 1'b0, w);
    chk(dat_out, 4'hF);
    @(negedge hclk);
    chk(dat_out, spd ? 4'h4 : 4'h0);
    for (int i = 0; i < 3; i++) begin
      @(posedge hclk);
      rx_valid <= 1'b1;
      rx_data <= 4'(i * 5 + 3);
      @(posedge hclk);
      rx_valid <= 1'b0;
      @(negedge hclk);
      chk({icl_out, dat_out}, {2'h2, 4'(i * 5 + 3)});
    end
    @(posedge hclk);
    rx_end <= 1'b1;
    @(posedge hclk);
    rx_end <= 1'b0;
    @(negedge hclk);
    chk(icl_out, 2'h0);
    // Flag raised during receive must still reach the link afterwards
    if (spd) get_status(2, st);
    if (spd) chk(st[3:0], 4'h4);
  endtask
  task t_tx(input logic [2:0] typ, input logic iso);
    logic [31:0] pk;
    pk = 32'hA5C3_1E2D;
    txq.delete();
    pfx_cnt = 0;
    lnk.send_req({10'h000, 1'b1, typ, 2'h0, 1'b0}, 7);
    w = 0;
    while (arb_req !== 1'b1 && w < 100) begin
      @(negedge hclk);
      w++;
    end
    chk(arb_req, 1'b1);
    chk(arb_iso, iso);
    @(posedge hclk);
    arb_won <= 1'b1;
    @(posedge hclk);
    arb_won <= 1'b0;
    grant(w);
    lnk.drive(LNK_HOLD, 4'h0);
    @(negedge hclk);
    chk({dat_oe_n, icl_oe_n}, 2'h3);
    repeat (2) lnk.drive(LNK_HOLD, 4'h0);
    lnk.packet(pk[31:16], LNK_HOLD);
    chk(32'(pfx_cnt >= (iso ? PREFIX_EXT_CYC : 1)), 32'h1);
    grant(w);
    chk(32'(w >= CONCAT_WAIT_CYC), 32'h1);
    lnk.packet(pk[15:0], LNK_IDLE);
    wait_icl(DEV_IDLE, 1'b0, w);
    chk(32'(w < 8), 32'h1);
    repeat (4) @(negedge hclk);
    chk(txq.size(), 8);
    for (int i = 0; i < 8 && i < txq.size(); i++) chk(txq[i], pk[31-4*i -: 4]);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    ev = 5'h00;
    arb_won = 1'b0;
    rx_start = 1'b0;
    rx_spd = 1'b0;
    rx_valid = 1'b0;
    rx_data = 4'h0;
    rx_end = 1'b0;
    mismatches = 0;
    tests_run = 0;
    pfx_cnt = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk({hreadyout, hresp, icl_oe_n, icl_out, dat_out}, 9'h100);
    t_flags;
    t_full;
    t_rx(1'b0);
    t_rx(1'b1);
    t_tx(RQ_FAIR, 1'b0);
    t_tx(RQ_PRI, 1'b0);
    ahb(1'b1, {20'h00000, REG_CTRL}, 32'h0000_0001, rd);
    t_tx(RQ_ISO, 1'b1);
    end_of_test;
  end
  // Whole run is a few hundred cycles; this is ample headroom
  initial begin
    #1250000;
    mismatches++;
    end_of_test;
  end
endmodule // test_phy_link_status_tx_rx
`default_nettype wire
